// ===== src/xfts_pkg.sv
// Constants and types shared by the frame timing sequencer.
// Assumes a 100 MHz ref_clk; every time below is counted on it.
package xfts_pkg;

   // Clock rate
   localparam int          CLK_MHZ    = 100;
   localparam logic [31:0] CYC_PER_MS = 32'(CLK_MHZ * 1000);

   // Timing modes
   localparam logic [1:0] MODE_FREE  = 2'h0;
   localparam logic [1:0] MODE_EXT   = 2'h1;
   localparam logic [1:0] MODE_SHUT2 = 2'h2;
   localparam logic [1:0] MODE_SHUT3 = 2'h3;

   // Times in milliseconds and microseconds
   localparam logic [15:0] READ_MS  = 16'h021C;  // 540 ms full readout
   localparam logic [15:0] CLEAR_MS = 16'h008C;  // 140 ms clearing scan
   localparam logic [15:0] MIN2_MS  = 16'h0096;  // 150 ms mode 2 floor
   localparam logic [15:0] MAX_MS   = 16'h82DC;  // 33500 ms ceiling
   localparam logic [15:0] MIN_MS   = 16'h0001;  // Avoids a zero period
   localparam int          GRST_US  = 10;
   localparam logic [31:0] GRST_CYC = 32'(GRST_US * CLK_MHZ);

   // Pixel widths and correction
   localparam int          ADC_W   = 12;
   localparam int          OFS_W   = 8;
   localparam logic [11:0] ADC_MAX = 12'hFFF;
   localparam logic [7:0]  OFS_MAX = 8'hFF;
   localparam logic [11:0] PED     = 12'h00A;   // 10 converter_count_unit

   // Array geometry: two sections grow outward from the centre row
   localparam int          ROWS   = 16;
   localparam int          HALF   = 8;
   localparam int          COLS   = 16;
   localparam int          ROW_W  = 3;
   localparam int          POS_W  = 4;
   localparam int          COL_W  = 4;
   localparam int          ADDR_W = 8;
   localparam int          WORD_W = ADDR_W + ADC_W;
   localparam int          FIFO_DEPTH = 8;
   localparam int          PV_W   = 128;
   localparam int          PV_H   = 124;

   // Sequencer states
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_GRST,
      ST_CLEAR,
      ST_INTEG,
      ST_READ
   } xfts_state_t;

endpackage

// ===== src/xfts_stream_if.sv
// Valid/ready word stream between the sequencer and its FIFO.
// Assumes both ends sit on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface xfts_stream_if #(parameter int W = 20);
   logic         valid;
   logic         ready;
   logic [W-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// ===== src/xfts_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock; the reader may stall to fill it.
`timescale 1ns/1ps
`default_nettype none
module xfts_fifo #(
   parameter int W     = 20,
   parameter int DEPTH = 8
) (
   // Clock and reset
   input  wire logic ref_clk,
   input  wire logic sys_rst,
   // Streams
   xfts_stream_if.snk wr,
   xfts_stream_if.src rd
);
   import xfts_pkg::*;
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [AW:0]             wp;
      logic [AW:0]             rp;
   } xfts_fifo_t;

   xfts_fifo_t r_reg;
   xfts_fifo_t r_next;
   logic       full;
   logic       empty;

   // Pointer wrap bit tells full from empty
   assign full  = (r_reg.wp[AW] != r_reg.rp[AW]) && (r_reg.wp[AW-1:0] == r_reg.rp[AW-1:0]);
   assign empty = (r_reg.wp == r_reg.rp);
   assign wr.ready = !full;
   assign rd.valid = !empty;
   assign rd.data  = r_reg.mem[r_reg.rp[AW-1:0]];

   // Push and pop may happen in one cycle
   always_comb begin
      r_next = r_reg;
      if (wr.valid && !full) begin
         r_next.mem[r_reg.wp[AW-1:0]] = wr.data;
         r_next.wp = r_reg.wp + 1'b1;
      end
      if (rd.ready && !empty) begin
         r_next.rp = r_reg.rp + 1'b1;
      end
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end

   a_fifo_full: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (wr.valid && full) |=> $stable(r_reg.wp))
      else $error("fifo accepted a word while full");
   c_fifo_fills: cover property (@(posedge ref_clk) disable iff (sys_rst) full);
endmodule
`default_nettype wire

// ===== src/xfts_seq.sv
// Frame timing and readout sequencer for a photodiode-array camera.
// Assumes ADC samples arrive on ref_clk; trigger pin is asynchronous.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Digitize 12 bits, place sections in image.
// - Mode 0 restarts readout each integration period.
// - Full readout scan takes 540 ms.
// - Short mode 0 period gives partial frame.
// - Scan from centre row outward both ways.
// - Reset each row as it is read.
// - Scan continuously; store next frame on save.
// - Integration time capped at 33.5 seconds.
// - External rising edge starts each readout.
// - Shutter trigger: reset, integrate, then read.
// - Mode 2: 10 us reset plus 140 ms clear.
// - Mode 3 skips the clearing scan.
// - Sync output high only during readout; frame_sync_out is also high during the mode 2 clearing scan.
// - Integration setting ignored in external mode.
// - Mode 2 integration at least 150 ms.
// - Offset frame saturates pixels to 255.
// - Corrected pixels get plus ten counts.
// - Correction only after offset frame stored.
// - Preview invalid until a frame is stored.
module xfts_seq #(
   parameter logic [31:0] MS_CYC = xfts_pkg::CYC_PER_MS
) (
   // Clock and reset
   input  wire logic                        ref_clk,
   input  wire logic                        sys_rst,
   // Host controls
   input  wire logic [1:0]                  mode,
   input  wire logic [15:0]                 integ_ms,
   input  wire logic                        save_req,
   input  wire logic                        ofs_req,
   input  wire logic                        corr_en,
   input  wire logic                        sw_trig,
   // Trigger pin
   input  wire logic                        ext_sync_in,
   // Converter samples, upper and lower section
   input  wire logic [xfts_pkg::ADC_W-1:0]  adc_up,
   input  wire logic [xfts_pkg::ADC_W-1:0]  adc_dn,
   // Array control
   output logic                             frame_sync_out,
   output logic                             arr_grst,
   output logic                             row_rst,
   output logic [xfts_pkg::POS_W-1:0]       row_up_sel,
   output logic [xfts_pkg::POS_W-1:0]       row_dn_sel,
   // Frame memory write stream
   output logic                             mem_valid,
   input  wire logic                        mem_ready,
   output logic [xfts_pkg::ADDR_W-1:0]      mem_addr,
   output logic [xfts_pkg::ADC_W-1:0]       mem_data,
   output logic [7:0]                       mem_pv_byte,
   // Status
   output logic                             frame_valid,
   output logic                             ofs_valid,
   output logic                             preview_valid,
   output logic                             corr_active,
   output logic                             busy
);
   import xfts_pkg::*;

   // Row dwell times for the normal and the clearing scan
   localparam logic [31:0] READ_ROW = 32'(READ_MS * MS_CYC / HALF);
   localparam logic [31:0] CLR_ROW  = 32'(CLEAR_MS * MS_CYC / HALF);
   localparam logic [ROW_W-1:0] ROW_LAST = ROW_W'(HALF - 1);
   localparam logic [COL_W-1:0] COL_LAST = COL_W'(COLS - 1);

   typedef struct packed {
      xfts_state_t      st;
      logic [31:0]      tmr;
      logic [31:0]      per;
      logic [ROW_W-1:0] row;
      logic [COL_W-1:0] col;
      logic             sec;
      logic             cols_done;
      logic             fast;
      logic             store;
      logic             ofs_run;
      logic             save_pend;
      logic             ofs_pend;
      logic             frame_valid;
      logic             ofs_valid;
      logic             row_rst;
      logic             grst;
      logic [2:0]       sync;
   } xfts_seq_t;

   xfts_seq_t r_reg, r_next;

   // Offset frame, one byte per pixel; no reset needed
   logic [OFS_W-1:0] ofs_mem [ROWS*COLS];
   xfts_stream_if #(.W(WORD_W)) in_s (), out_s ();

   logic               trig_edge, scanning, push_v, adv, ofs_we;
   logic [15:0]        ms_lim;
   logic [31:0]        integ_cyc, row_len;
   logic [POS_W-1:0]   pos;
   logic [ADDR_W-1:0]  addr;
   logic [ADC_W-1:0]   sample, corr_pix, pix;
   logic [OFS_W-1:0]   ofs, ofs_wdata;
   logic signed [13:0] diff;
   // Edge seen on the second and third flops only
   assign trig_edge = r_reg.sync[1] && !r_reg.sync[2];

   // Integration setting, clamped; the external mode never reads it
   always_comb begin
      ms_lim = (integ_ms > MAX_MS) ? MAX_MS : integ_ms;
      if (mode == MODE_SHUT2 && ms_lim < MIN2_MS) begin
         ms_lim = MIN2_MS;
      end
      if (ms_lim < MIN_MS) begin
         ms_lim = MIN_MS;
      end
   end
   assign integ_cyc = 32'(48'(ms_lim) * 48'(MS_CYC));
   assign row_len   = r_reg.fast ? CLR_ROW : READ_ROW;

   // Pixel position: upper section walks up, lower walks down
   assign pos    = r_reg.sec ? POS_W'(HALF) + {1'b0, r_reg.row}
                             : POS_W'(HALF - 1) - {1'b0, r_reg.row};
   assign addr   = {pos, r_reg.col};
   assign sample = r_reg.sec ? adc_dn : adc_up;
   assign ofs    = ofs_mem[addr];

   // Offset saturation and pedestal-shifted subtraction
   assign ofs_wdata = (sample > {4'h0, OFS_MAX}) ? OFS_MAX : sample[7:0];
   assign diff = $signed({2'b00, sample}) + $signed({2'b00, PED})
               - $signed({6'h00, ofs});
   always_comb begin
      if (diff < 0) begin
         corr_pix = 12'h000;
      end else if (diff > $signed({2'b00, ADC_MAX})) begin
         corr_pix = ADC_MAX;
      end else begin
         corr_pix = diff[11:0];
      end
   end
   assign corr_active = corr_en && r_reg.ofs_valid;
   assign pix = corr_active ? corr_pix : sample;

   // Sampling stalls while the FIFO is full, so no pixel is dropped
   assign scanning = (r_reg.st == ST_READ) && !r_reg.cols_done;
   assign push_v   = scanning && r_reg.store && !r_reg.ofs_run;
   assign ofs_we   = scanning && r_reg.store && r_reg.ofs_run;
   assign adv      = scanning && (!push_v || in_s.ready);
   assign in_s.valid = push_v;
   assign in_s.data  = {addr, pix};

   // Readout start; pending save or offset requests pick the frame
   function automatic xfts_seq_t start_rd(input xfts_seq_t s, input logic keep);
      start_rd = s;
      start_rd.st        = ST_READ;
      start_rd.tmr       = 32'h0;
      start_rd.row       = '0;
      start_rd.col       = '0;
      start_rd.sec       = 1'b0;
      start_rd.cols_done = 1'b0;
      start_rd.fast      = 1'b0;
      start_rd.grst      = 1'b0;
      start_rd.store     = keep || s.save_pend || s.ofs_pend;
      start_rd.ofs_run   = s.ofs_pend;
      start_rd.ofs_pend  = 1'b0;
      start_rd.save_pend = s.save_pend && s.ofs_pend;
   endfunction

   // Sequencer next state
   always_comb begin
      r_next = r_reg;
      r_next.row_rst = 1'b0;
      r_next.sync = {r_reg.sync[1:0], ext_sync_in};
      case (r_reg.st)
         ST_IDLE: begin
            if (mode == MODE_EXT && trig_edge) begin
               r_next = start_rd(r_next, 1'b0);
            end else if (mode[1] && (trig_edge || sw_trig)) begin
               r_next.st   = ST_GRST;
               r_next.tmr  = 32'h0;
               r_next.grst = 1'b1;
            end
         end
         ST_GRST: begin
            r_next.tmr = r_reg.tmr + 32'h1;
            if (r_reg.tmr >= GRST_CYC - 32'h1) begin
               r_next.grst = 1'b0;
               r_next.tmr  = 32'h0;
               if (mode == MODE_SHUT2) begin
                  r_next.st        = ST_CLEAR;
                  r_next.row       = '0;
                  r_next.fast      = 1'b1;
                  r_next.cols_done = 1'b1;
               end else begin
                  r_next.st = ST_INTEG;
               end
            end
         end
         ST_INTEG: begin
            r_next.tmr = r_reg.tmr + 32'h1;
            if (!mode[1]) begin
               r_next.st = ST_IDLE;
            end else if (r_reg.tmr >= integ_cyc - 32'h1) begin
               r_next = start_rd(r_next, 1'b1);
            end
         end
         ST_CLEAR, ST_READ: begin
            r_next.tmr = r_reg.tmr + 32'h1;
            // Two sections per column, upper first
            if (adv) begin
               if (r_reg.sec) begin
                  r_next.sec = 1'b0;
                  if (r_reg.col == COL_LAST) begin
                     r_next.cols_done = 1'b1;
                  end else begin
                     r_next.col = r_reg.col + 1'b1;
                  end
               end else begin
                  r_next.sec = 1'b1;
               end
            end
            // Row ends when its dwell is over and its pixels are taken
            if (r_reg.tmr >= row_len - 32'h1 && r_reg.cols_done) begin
               r_next.row_rst   = 1'b1;
               r_next.tmr       = 32'h0;
               r_next.col       = '0;
               r_next.sec       = 1'b0;
               r_next.cols_done = r_reg.fast;
               if (r_reg.row == ROW_LAST) begin
                  if (r_reg.fast) begin
                     r_next.st   = ST_INTEG;
                     r_next.fast = 1'b0;
                  end else begin
                     r_next.st    = ST_IDLE;
                     r_next.store = 1'b0;
                     if (r_reg.store && r_reg.ofs_run) begin
                        r_next.ofs_valid = 1'b1;
                     end else if (r_reg.store) begin
                        r_next.frame_valid = 1'b1;
                     end
                  end
               end else begin
                  r_next.row = r_reg.row + 1'b1;
               end
            end
         end
         default: begin
            r_next.st = ST_IDLE;
         end
      endcase
      // Free-running period cuts any scan short; with a period shorter than a scan only centre rows update
      if (mode == MODE_FREE) begin
         r_next.per = r_reg.per + 32'h1;
         if (r_reg.per >= integ_cyc - 32'h1) begin
            r_next.per = 32'h0;
            if (r_reg.st == ST_READ && r_reg.store) begin
               r_next.frame_valid = r_reg.frame_valid || !r_reg.ofs_run;
               r_next.ofs_valid   = r_reg.ofs_valid || r_reg.ofs_run;
            end
            r_next = start_rd(r_next, 1'b0);
         end
      end else begin
         r_next.per = 32'h0;
      end
      // A request in the cycle it is consumed stays pending
      if (save_req) begin
         r_next.save_pend = 1'b1;
      end
      if (ofs_req) begin
         r_next.ofs_pend = 1'b1;
      end
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end

   // Offset frame store
   always_ff @(posedge ref_clk) begin
      if (ofs_we && adv) begin
         ofs_mem[addr] <= ofs_wdata;
      end
   end

   // Eight words absorb short stalls of the memory side
   xfts_fifo #(
      .W     (WORD_W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .ref_clk (ref_clk),
      .sys_rst (sys_rst),
      .wr      (in_s.snk),
      .rd      (out_s.src)
   );

   // Outputs
   assign frame_sync_out = (r_reg.st == ST_READ) || (r_reg.st == ST_CLEAR);
   assign arr_grst       = r_reg.grst;
   assign row_rst        = r_reg.row_rst;
   assign row_up_sel     = POS_W'(HALF - 1) - {1'b0, r_reg.row};
   assign row_dn_sel     = POS_W'(HALF) + {1'b0, r_reg.row};
   assign mem_valid      = out_s.valid;
   assign out_s.ready    = mem_ready;
   assign mem_addr       = out_s.data[WORD_W-1:ADC_W];
   assign mem_data       = out_s.data[ADC_W-1:0];
   assign mem_pv_byte    = out_s.data[ADC_W-1:ADC_W-8];
   assign frame_valid    = r_reg.frame_valid;
   assign ofs_valid      = r_reg.ofs_valid;
   assign preview_valid  = r_reg.frame_valid;
   assign busy           = (r_reg.st != ST_IDLE);

   // Checking helpers: length of the global reset pulse
   logic [31:0] grst_len;
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         grst_len <= 32'h0;
      end else if (r_reg.grst) begin
         grst_len <= grst_len + 32'h1;
      end else begin
         grst_len <= 32'h0;
      end
   end

   a_grst_width: assert property (@(posedge ref_clk) disable iff (sys_rst)
      $fell(arr_grst) |-> (grst_len == GRST_CYC))
      else $error("global reset pulse has the wrong length");
   a_mode2_clears: assert property (@(posedge ref_clk) disable iff (sys_rst)
      ($fell(arr_grst) && $past(mode) == MODE_SHUT2) |-> r_reg.st == ST_CLEAR)
      else $error("mode 2 skipped the clearing scan");
   a_mode3_noclear: assert property (@(posedge ref_clk) disable iff (sys_rst)
      ($fell(arr_grst) && $past(mode) == MODE_SHUT3) |-> r_reg.st == ST_INTEG)
      else $error("mode 3 did not go straight to integration");
   a_ext_edge: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (mode == MODE_EXT && r_reg.st == ST_IDLE && trig_edge) |=> r_reg.st == ST_READ)
      else $error("external edge did not start a readout");
   a_trig_ignored: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (r_reg.st == ST_READ && mode != MODE_FREE && (sw_trig || trig_edge))
         |=> (r_reg.st != ST_GRST) && (r_reg.tmr != 32'h0 || r_reg.row_rst))
      else $error("trigger restarted a running sequence");
   a_row_in_read: assert property (@(posedge ref_clk) disable iff (sys_rst)
      row_rst |-> $past(frame_sync_out) && !arr_grst)
      else $error("row reset outside a readout");
   a_corr_gate: assert property (@(posedge ref_clk) disable iff (sys_rst)
      $rose(ofs_valid) |-> $past(r_reg.store) && $past(r_reg.ofs_run))
      else $error("offset frame flagged without an offset scan");
   a_pedestal: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (push_v && corr_active && sample >= {4'h0, ofs})
         |-> in_s.data[ADC_W-1:0] == ADC_W'(sample + PED - {4'h0, ofs})
          || in_s.data[ADC_W-1:0] == ADC_MAX)
      else $error("corrected pixel lacks the pedestal");
   a_integ_max: assert property (@(posedge ref_clk) disable iff (sys_rst)
      integ_cyc <= 32'(48'(MAX_MS) * 48'(MS_CYC)))
      else $error("integration time above ceiling");
   a_mode2_min: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (mode == MODE_SHUT2) |-> integ_cyc >= 32'(48'(MIN2_MS) * 48'(MS_CYC)))
      else $error("mode 2 integration below floor");

   c_shutter_read: cover property (@(posedge ref_clk) disable iff (sys_rst)
      $fell(arr_grst) ##[1:1000] r_reg.st == ST_READ);
   c_ext_start: cover property (@(posedge ref_clk) disable iff (sys_rst)
      mode == MODE_EXT && trig_edge && r_reg.st == ST_IDLE);
   c_frame_stored: cover property (@(posedge ref_clk) disable iff (sys_rst) $rose(frame_valid));
   c_corr_push: cover property (@(posedge ref_clk) disable iff (sys_rst) push_v && corr_active);
endmodule
`default_nettype wire

// ===== tb/xfts_sensor_model.sv
// Behavioural sensor sections and trigger source facing the sequencer.
// Assumes the bench sets the scene pattern and asks for trigger edges.
`timescale 1ns/1ps
`default_nettype none
module xfts_sensor_model (
   // Clock
   input  wire logic        ref_clk,
   // Bench controls
   input  wire logic [7:0]  pat,
   input  wire logic        fire,
   // Row selects from the sequencer
   input  wire logic [3:0]  row_up_sel,
   input  wire logic [3:0]  row_dn_sel,
   // Pixels and trigger pin
   output logic      [11:0] adc_up,
   output logic      [11:0] adc_dn,
   output logic             ext_sync_in
);
   logic [3:0] hi_cnt = 4'h0;
   // Pixel follows the selected row, so sink stalls cannot shift it
   assign adc_up = {pat, row_up_sel};
   assign adc_dn = {~pat, row_dn_sel};
   // Pin held high eight cycles; spacing of edges sets integration
   always @(posedge ref_clk) begin
      if (fire) hi_cnt <= 4'h8;
      else if (hi_cnt != 4'h0) hi_cnt <= hi_cnt - 4'h1;
   end
   assign ext_sync_in = (hi_cnt != 4'h0);
endmodule
`default_nettype wire

// ===== tb/tb_top.sv
// Self-checking bench: drives the sequencer and scores its pixel stream.
// Assumes m_sensor supplies pixels and trigger pin; MS_CYC runs at 40.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import xfts_pkg::*;
   logic        ref_clk = 1'b0;
   logic        sys_rst = 1'b1;
   logic [1:0]  mode = 2'h1;
   logic [15:0] integ_ms = 16'h0001;
   logic        save_req = 1'b0, ofs_req = 1'b0, corr_en = 1'b0, sw_trig = 1'b0;
   logic        fire = 1'b0, mem_ready = 1'b0, chk_on = 1'b1;
   logic [7:0]  pat = 8'h3C, mem_addr, mem_pv_byte;
   logic [11:0] adc_up, adc_dn, mem_data;
   logic [3:0]  row_up_sel, row_dn_sel;
   logic        ext_sync_in, frame_sync_out, arr_grst, row_rst, mem_valid;
   logic        frame_valid, ofs_valid, preview_valid, corr_active, busy;
   logic [19:0] exp_q[$];
   logic [19:0] w;
   int          n_fail = 0, tests_run = 0, cyc = 0, stall_to = 0, n_rows = 0;
   int          seed = 54302, wt, len, n;

   // Short ms keeps a full frame near 21600 cycles
   xfts_seq #(.MS_CYC(32'h28)) i_xfts_seq (.ref_clk, .sys_rst, .mode, .integ_ms,
      .save_req, .ofs_req, .corr_en, .sw_trig, .ext_sync_in, .adc_up, .adc_dn,
      .frame_sync_out, .arr_grst, .row_rst, .row_up_sel, .row_dn_sel, .mem_valid,
      .mem_ready, .mem_addr, .mem_data, .mem_pv_byte, .frame_valid, .ofs_valid,
      .preview_valid, .corr_active, .busy);
   xfts_sensor_model m_sensor (.ref_clk, .pat, .fire, .row_up_sel, .row_dn_sel,
      .adc_up, .adc_dn, .ext_sync_in);

   // Clock
   always #5 ref_clk = ~ref_clk;

   // Sink stalls to fill the FIFO, then random ready; cycle ceiling
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      mem_ready <= (cyc > stall_to) && ($random(seed) % 3 != 0);
      if (row_rst === 1'b1) n_rows <= n_rows + 1;
      if (cyc == 100000) begin
         n_fail++;
         $display("Timeout, cycle limit reached");
         stop_test();
      end
   end

   // Scoreboard: each accepted word against the oldest note
   always @(posedge ref_clk) begin
      if (chk_on && mem_valid === 1'b1 && mem_ready === 1'b1) begin
         w = (exp_q.size() != 0) ? exp_q.pop_front() : 20'hFFFFF;
         chk("mem_addr", mem_addr, w[19:12]);
         chk("mem_data", mem_data, w[11:0]);
         chk("mem_pv_byte", mem_pv_byte, w[11:4]);
      end
   end

   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
      end
   endtask

   task automatic stop_test();
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic pulse(input logic s, input logic f, input logic o, input logic t);
      @(posedge ref_clk);
      save_req <= s;
      fire <= f;
      ofs_req <= o;
      sw_trig <= t;
      @(posedge ref_clk);
      {save_req, fire, ofs_req, sw_trig} <= 4'h0;
   endtask

   // Notes one frame: centre rows outward, upper then lower per column
   task automatic expect_frame(input logic [7:0] p, input logic [7:0] op, input bit corr);
      int s;
      int o;
      logic [3:0] r;
      for (int i = 0; i < 256; i++) begin
         r = i[0] ? 4'(8 + i / 32) : 4'(7 - i / 32);
         s = i[0] ? {~p, r} : {p, r};
         o = i[0] ? {~op, r} : {op, r};
         o = (o > int'(OFS_MAX)) ? int'(OFS_MAX) : o;
         if (corr) s = s + int'(PED) - o;
         s = (s < 0) ? 0 : (s > 4095) ? 4095 : s;
         exp_q.push_back({r, 4'(i[4:1]), 12'(s)});
      end
   endtask

   task automatic sync_high(input int max_hi, output int lo, output int hi);
      lo = 0;
      hi = 0;
      while (frame_sync_out !== 1'b1 && lo < 8000) begin
         @(negedge ref_clk);
         lo++;
      end
      while (frame_sync_out === 1'b1 && hi < max_hi) begin
         @(negedge ref_clk);
         hi++;
      end
   endtask

   task automatic grst_len();
      n = 0;
      @(negedge ref_clk);
      while (arr_grst === 1'b1 && n < 2000) begin
         @(negedge ref_clk);
         n++;
      end
      chk("grst_len", n, 1000);
   endtask

   task automatic drain();
      n = 0;
      while (exp_q.size() != 0 && n < 3000) begin
         @(negedge ref_clk);
         n++;
      end
      repeat (20) @(negedge ref_clk);
      chk("left_words", exp_q.size(), 0);
   endtask

   // Main sequence
   initial begin
      repeat (16) @(posedge ref_clk);
      sys_rst <= 1'b0;
      @(negedge ref_clk);
      chk("preview_valid", preview_valid, 1'b0);
      expect_frame(8'h3C, 8'h00, 1'b0);
      stall_to <= cyc + 200;
      n = n_rows;
      pulse(1'b1, 1'b1, 1'b0, 1'b0);
      sync_high(30000, wt, len);
      chk("read_len", len >= 21600 && len <= 21620, 1'b1);
      @(negedge ref_clk);
      chk("row_resets", n_rows - n, 8);
      drain();
      chk("frame_valid", frame_valid, 1'b1);
      chk("preview_valid", preview_valid, 1'b1);
      $display("test 1 done");
      @(posedge ref_clk);
      chk_on <= 1'b0;
      pat <= 8'hF0;
      corr_en <= 1'b1;
      @(negedge ref_clk);
      chk("corr_active", corr_active, 1'b0);
      pulse(1'b0, 1'b1, 1'b1, 1'b0);
      sync_high(30000, wt, len);
      repeat (80) @(negedge ref_clk);
      chk("ofs_valid", ofs_valid, 1'b1);
      chk("corr_active", corr_active, 1'b1);
      $display("test 2 done");
      @(posedge ref_clk);
      chk_on <= 1'b1;
      mode <= MODE_SHUT3;
      pat <= 8'hA5;
      expect_frame(8'hA5, 8'hF0, 1'b1);
      pulse(1'b0, 1'b0, 1'b0, 1'b1);
      grst_len();
      sync_high(100, wt, len);
      chk("integ_wait", wt >= 39 && wt <= 42, 1'b1);
      pulse(1'b0, 1'b1, 1'b0, 1'b1);
      sync_high(30000, wt, len);
      drain();
      chk("busy", busy, 1'b0);
      chk("arr_grst", arr_grst, 1'b0);
      $display("test 3 done");
      @(posedge ref_clk);
      chk_on <= 1'b0;
      mode <= MODE_SHUT2;
      pulse(1'b0, 1'b0, 1'b0, 1'b1);
      grst_len();
      sync_high(6000, wt, len);
      chk("clear_len", len >= 5600 && len <= 5602, 1'b1);
      sync_high(4, wt, len);
      chk("integ_floor", wt >= 6000 && wt <= 6002, 1'b1);
      $display("test 4 done");
      @(posedge ref_clk);
      sys_rst <= 1'b1;
      mode <= MODE_FREE;
      integ_ms <= 16'h0064;
      repeat (2) @(posedge ref_clk);
      sys_rst <= 1'b0;
      @(negedge ref_clk);
      chk("ofs_valid", ofs_valid, 1'b0);
      repeat (4100) @(negedge ref_clk);
      n = n_rows;
      wt = 0;
      pulse(1'b1, 1'b0, 1'b0, 1'b0);
      for (int i = 0; i < 12000; i++) begin
         @(negedge ref_clk);
         if (row_up_sel < 4'h6 || row_dn_sel > 4'h9) wt++;
      end
      chk("period_rows", n_rows - n, 3);
      chk("row_span", wt, 0);
      chk("frame_valid", frame_valid, 1'b1);
      $display("test 5 done");
      stop_test();
   end
endmodule
`default_nettype wire
